// ### logic/temp_regs_pkg.sv
// Purpose: Shared constants for the thermometer register access block.
// Assumes: Pointer codes are the first data byte, sent after the address, in a bus write.
// Notes:   Read and write locations differ for the limit registers, except the remote low-byte limits at 0x13 and 0x14.
package temp_regs_pkg;
   // Converter code: unsigned eighths of a degree, 0.000 to 127.875.
   localparam int         CODE_W      = 10;
   localparam int         FRAC_W      = 3;
   localparam int         PAD_W       = 5;
   localparam int         FLAG_N      = 4;
   localparam int         LSB_MDEG    = 125;
   localparam logic [2:0] LAST_BIT    = 3'h7;
   localparam logic [7:0] PTR_RD_LOC  = 8'h00;
   localparam logic [7:0] PTR_RD_REMH = 8'h01;
   localparam logic [7:0] PTR_RD_LHI  = 8'h05;
   localparam logic [7:0] PTR_RD_LLO  = 8'h06;
   localparam logic [7:0] PTR_RD_RHI  = 8'h07;
   localparam logic [7:0] PTR_RD_RLO  = 8'h08;
   localparam logic [7:0] PTR_RD_REML = 8'h10;
   localparam logic [7:0] PTR_RD_RHIL = 8'h13;
   localparam logic [7:0] PTR_RD_RLOL = 8'h14;
   localparam logic [7:0] PTR_WR_LHI  = 8'h0b;
   localparam logic [7:0] PTR_WR_LLO  = 8'h0c;
   localparam logic [7:0] PTR_WR_RHI  = 8'h0d;
   localparam logic [7:0] PTR_WR_RLO  = 8'h0e;
   localparam logic [7:0] PTR_WR_RHIL = 8'h13;
   localparam logic [7:0] PTR_WR_RLOL = 8'h14;
   localparam logic [7:0] VALUE_RST   = 8'h80;
   localparam logic [7:0] LOWB_RST    = 8'h00;
   localparam logic [7:0] HI_LIM_RST  = 8'h7f;
   localparam logic [7:0] LO_LIM_RST  = 8'hc9;
   localparam logic [7:0] PTR_RST     = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   localparam int         FLAG_LHIGH  = 3;
   localparam int         FLAG_LLOW   = 2;
   localparam int         FLAG_RHIGH  = 1;
   localparam int         FLAG_RLOW   = 0;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_AACK  = 3'b010,
      ST_WRITE = 3'b011,
      ST_WACK  = 3'b100,
      ST_READ  = 3'b101,
      ST_RACK  = 3'b110,
      ST_RNEXT = 3'b111
   } bus_state_t;
endpackage : temp_regs_pkg

// ### logic/pin_sync3.sv
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to clk.
// Notes:   The output moves only when stages two and three agree.
`timescale 1ns/1ps
module pin_sync3 #(
   parameter int         W   = 2,
   parameter logic [1:0] RST = 2'h3
)(
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1_r, s2_r, s3_r, dout_r;
   logic [W-1:0] dout_nxt;

   generate
      if (W != 2) begin : g_chk
         $error("pin_sync3 serves exactly two pins");
      end
   endgenerate

   always_comb begin
      dout_nxt = dout_r;
      for (int i = 0; i < W; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            dout_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_r   <= RST;
         s2_r   <= RST;
         s3_r   <= RST;
         dout_r <= RST;
      end else begin
         s1_r   <= din;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         dout_r <= dout_nxt;
      end
   end

   assign dout = dout_r;
endmodule : pin_sync3

// ### logic/temp_monitor_register_access.sv
// Purpose: Bus target and value registers of a two-channel thermometer.
// Assumes: Converter gives unsigned eighths of a degree with a valid pulse.
// Notes:   Unmapped or wrong-direction reads return zero.
// Function
// - One converter LSB is one eighth of a degree Celsius.
// - Only zero to 127.875 degrees is reported; no negative codes.
// - Each conversion writes whole degrees, top bit zero, to the local byte and remote high byte.
// - Remote low byte holds eighths in its top three bits, rest zero.
// - After each store, compare both channels with their high and low limits.
// - Limit registers have separate read and write locations, except the remote low-byte limits, which share 0x13 and 0x14.
// - First data byte of every write loads the register pointer.
// - Pointer selects second write byte and later reads.
// - The pointer has no address; only the first write byte reaches it.
// - Temperature value registers change only from the converter.
// - Remote result is eleven bits split over high and low bytes.
// - Local and remote high values start at minus 128 degrees.
`timescale 1ns/1ps
module temp_monitor_register_access #(
   parameter logic [6:0] DEV_ADDR = 7'h4c
)(
   input  wire logic                              clk,
   input  wire logic                              rstn,
   input  wire logic                              scl_pin,
   input  wire logic                              sda_pin,
   output logic                                   sda_out,
   output logic                                   sda_oe_n,
   input  wire logic                              conv_valid,
   input  wire logic [temp_regs_pkg::CODE_W-1:0]  conv_local,
   input  wire logic [temp_regs_pkg::CODE_W-1:0]  conv_remote,
   output logic      [temp_regs_pkg::FLAG_N-1:0]  limit_flags
);
   import temp_regs_pkg::*;

   generate
      if (DEV_ADDR == 7'h00) begin : g_chk
         $error("device address must not be the general call address");
      end
   endgenerate

   logic [1:0] pins_s;
   logic       scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;

   pin_sync3 #(.W(2), .RST(2'h3)) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .din  ({scl_pin, sda_pin}),
      .dout (pins_s)
   );

   // Bus group.
   bus_state_t state_r, state_nxt;
   logic [2:0] bit_cnt_r, bit_cnt_nxt;
   logic [7:0] shift_r, shift_nxt, ptr_r, ptr_nxt, rd_byte, wr_byte;
   logic       first_r, first_nxt, rw_r, rw_nxt, oe_n_r, oe_n_nxt;
   logic       scl_q_r, sda_q_r, sda_o_r;
   logic [7:0] lhi_r, llo_r, rhi_r, rlo_r, rhil_r, rlol_r;
   logic [7:0] lhi_nxt, llo_nxt, rhi_nxt, rlo_nxt, rhil_nxt, rlol_nxt;

   // Value group.
   logic [7:0]        loc_r, loc_nxt, remh_r, remh_nxt, reml_r, reml_nxt;
   logic              cmp_r, seen_r;
   logic [FLAG_N-1:0] flags_r, flags_nxt, flags_now;
   logic signed [10:0] rem11, rhi11, rlo11;

   assign scl_s    = pins_s[1];
   assign sda_s    = pins_s[0];
   assign scl_rise = scl_s & ~scl_q_r;
   assign scl_fall = ~scl_s & scl_q_r;
   assign start_c  = scl_s & scl_q_r & sda_q_r & ~sda_s;
   assign stop_c   = scl_s & scl_q_r & ~sda_q_r & sda_s;
   assign wr_byte  = {shift_r[6:0], sda_s};

   // Read locations only; write-only locations answer zero.
   always_comb begin
      case (ptr_r)
         PTR_RD_LOC:  rd_byte = loc_r;
         PTR_RD_REMH: rd_byte = remh_r;
         PTR_RD_REML: rd_byte = reml_r;
         PTR_RD_LHI:  rd_byte = lhi_r;
         PTR_RD_LLO:  rd_byte = llo_r;
         PTR_RD_RHI:  rd_byte = rhi_r;
         PTR_RD_RLO:  rd_byte = rlo_r;
         PTR_RD_RHIL: rd_byte = rhil_r;
         PTR_RD_RLOL: rd_byte = rlol_r;
         default:     rd_byte = RD_UNMAPPED;
      endcase
   end

   always_comb begin
      state_nxt   = state_r;
      bit_cnt_nxt = bit_cnt_r;
      shift_nxt   = shift_r;
      ptr_nxt     = ptr_r;
      first_nxt   = first_r;
      rw_nxt      = rw_r;
      oe_n_nxt    = oe_n_r;
      lhi_nxt     = lhi_r;
      llo_nxt     = llo_r;
      rhi_nxt     = rhi_r;
      rlo_nxt     = rlo_r;
      rhil_nxt    = rhil_r;
      rlol_nxt    = rlol_r;
      if (stop_c) begin
         state_nxt = ST_IDLE;
         oe_n_nxt  = 1'b1;
      end else if (start_c) begin
         state_nxt   = ST_ADDR;
         bit_cnt_nxt = 3'h0;
         first_nxt   = 1'b1;
         oe_n_nxt    = 1'b1;
      end else begin
         case (state_r)
            ST_ADDR: begin
               if (scl_rise) begin
                  shift_nxt   = wr_byte;
                  bit_cnt_nxt = bit_cnt_r + 3'h1;
                  if (bit_cnt_r == LAST_BIT) begin
                     state_nxt = ST_AACK;
                  end
               end
            end
            ST_AACK: begin
               if (scl_fall && oe_n_r) begin
                  if (shift_r[7:1] == DEV_ADDR) begin
                     oe_n_nxt = 1'b0;
                     rw_nxt   = shift_r[0];
                  end else begin
                     state_nxt = ST_IDLE;
                  end
               end else if (scl_fall) begin
                  bit_cnt_nxt = 3'h0;
                  if (rw_r) begin
                     shift_nxt = rd_byte;
                     oe_n_nxt  = rd_byte[7];
                     state_nxt = ST_READ;
                  end else begin
                     oe_n_nxt  = 1'b1;
                     state_nxt = ST_WRITE;
                  end
               end
            end
            ST_WRITE: begin
               if (scl_rise) begin
                  shift_nxt   = wr_byte;
                  bit_cnt_nxt = bit_cnt_r + 3'h1;
                  if (bit_cnt_r == LAST_BIT) begin
                     state_nxt = ST_WACK;
                     if (first_r) begin
                        ptr_nxt   = wr_byte;
                        first_nxt = 1'b0;
                     end else begin
                        // Value registers have no write location.
                        case (ptr_r)
                           PTR_WR_LHI:  lhi_nxt  = wr_byte;
                           PTR_WR_LLO:  llo_nxt  = wr_byte;
                           PTR_WR_RHI:  rhi_nxt  = wr_byte;
                           PTR_WR_RLO:  rlo_nxt  = wr_byte;
                           PTR_WR_RHIL: rhil_nxt = wr_byte;
                           PTR_WR_RLOL: rlol_nxt = wr_byte;
                           default:     ;
                        endcase
                     end
                  end
               end
            end
            ST_WACK: begin
               if (scl_fall && oe_n_r) begin
                  oe_n_nxt = 1'b0;
               end else if (scl_fall) begin
                  oe_n_nxt    = 1'b1;
                  bit_cnt_nxt = 3'h0;
                  state_nxt   = ST_WRITE;
               end
            end
            ST_READ: begin
               if (scl_rise) begin
                  bit_cnt_nxt = bit_cnt_r + 3'h1;
                  if (bit_cnt_r == LAST_BIT) begin
                     state_nxt = ST_RACK;
                  end
               end else if (scl_fall) begin
                  shift_nxt = {shift_r[6:0], 1'b0};
                  oe_n_nxt  = shift_r[6];
               end
            end
            ST_RACK: begin
               if (scl_fall) begin
                  oe_n_nxt = 1'b1;
               end else if (scl_rise) begin
                  state_nxt = sda_s ? ST_IDLE : ST_RNEXT;
               end
            end
            ST_RNEXT: begin
               // Repeated bytes come from the same location.
               if (scl_fall) begin
                  shift_nxt   = rd_byte;
                  oe_n_nxt    = rd_byte[7];
                  bit_cnt_nxt = 3'h0;
                  state_nxt   = ST_READ;
               end
            end
            default: begin
               oe_n_nxt = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r   <= ST_IDLE;
         bit_cnt_r <= 3'h0;
         shift_r   <= 8'h00;
         ptr_r     <= PTR_RST;
         first_r   <= 1'b0;
         rw_r      <= 1'b0;
         oe_n_r    <= 1'b1;
         scl_q_r   <= 1'b1;
         sda_q_r   <= 1'b1;
         sda_o_r   <= 1'b0;
         lhi_r     <= HI_LIM_RST;
         llo_r     <= LO_LIM_RST;
         rhi_r     <= HI_LIM_RST;
         rlo_r     <= LO_LIM_RST;
         rhil_r    <= LOWB_RST;
         rlol_r    <= LOWB_RST;
      end else begin
         state_r   <= state_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         shift_r   <= shift_nxt;
         ptr_r     <= ptr_nxt;
         first_r   <= first_nxt;
         rw_r      <= rw_nxt;
         oe_n_r    <= oe_n_nxt;
         scl_q_r   <= scl_s;
         sda_q_r   <= sda_s;
         sda_o_r   <= 1'b0;
         lhi_r     <= lhi_nxt;
         llo_r     <= llo_nxt;
         rhi_r     <= rhi_nxt;
         rlo_r     <= rlo_nxt;
         rhil_r    <= rhil_nxt;
         rlol_r    <= rlol_nxt;
      end
   end

   // Limits are signed; stored values never go negative.
   assign rem11 = {remh_r, reml_r[7:PAD_W]};
   assign rhi11 = {rhi_r, rhil_r[7:PAD_W]};
   assign rlo11 = {rlo_r, rlol_r[7:PAD_W]};

   always_comb begin
      flags_now             = '0;
      flags_now[FLAG_LHIGH] = $signed(loc_r) > $signed(lhi_r);
      flags_now[FLAG_LLOW]  = $signed(loc_r) < $signed(llo_r);
      flags_now[FLAG_RHIGH] = rem11 > rhi11;
      flags_now[FLAG_RLOW]  = rem11 < rlo11;
   end

   always_comb begin
      loc_nxt   = loc_r;
      remh_nxt  = remh_r;
      reml_nxt  = reml_r;
      flags_nxt = cmp_r ? flags_now : flags_r;
      if (conv_valid) begin
         // Code in eighths: upper bits are whole degrees, sign bit zero.
         loc_nxt  = {1'b0, conv_local[CODE_W-1:FRAC_W]};
         remh_nxt = {1'b0, conv_remote[CODE_W-1:FRAC_W]};
         reml_nxt = {conv_remote[FRAC_W-1:0], {PAD_W{1'b0}}};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         loc_r   <= VALUE_RST;
         remh_r  <= VALUE_RST;
         reml_r  <= LOWB_RST;
         cmp_r   <= 1'b0;
         seen_r  <= 1'b0;
         flags_r <= '0;
      end else begin
         loc_r   <= loc_nxt;
         remh_r  <= remh_nxt;
         reml_r  <= reml_nxt;
         cmp_r   <= conv_valid;
         seen_r  <= seen_r | conv_valid;
         flags_r <= flags_nxt;
      end
   end

   assign sda_out     = sda_o_r;
   assign sda_oe_n    = oe_n_r;
   assign limit_flags = flags_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence last_wr_bit_s;
      state_r == ST_WRITE && scl_rise && bit_cnt_r == LAST_BIT
         && !start_c && !stop_c;
   endsequence
   sequence stored_s;
      conv_valid ##1 1'b1;
   endsequence

   ptr_load_a: assert property (last_wr_bit_s and first_r
      |=> ptr_r == $past(wr_byte))
      else $error("first write byte did not load the pointer");
   ptr_hold_a: assert property (!(state_r == ST_WRITE && scl_rise)
      |=> $stable(ptr_r))
      else $error("pointer changed outside a first write byte");
   values_ro_a: assert property (!conv_valid
      |=> $stable(loc_r) && $stable(remh_r) && $stable(reml_r))
      else $error("value register changed without a conversion");
   whole_fmt_a: assert property (conv_valid
      |=> loc_r == {1'b0, $past(conv_local[CODE_W-1:FRAC_W])}
          && !remh_r[7])
      else $error("whole degree byte malformed");
   frac_fmt_a: assert property (conv_valid
      |=> reml_r[PAD_W-1:0] == '0
          && reml_r[7:PAD_W] == $past(conv_remote[FRAC_W-1:0]))
      else $error("fraction byte malformed");
   limit_cmp_a: assert property (stored_s
      |=> limit_flags == $past(flags_now))
      else $error("limit flags not compared after store");
   dual_addr_a: assert property (last_wr_bit_s and !first_r
      and ptr_r == PTR_WR_LHI |=> lhi_r == $past(wr_byte))
      else $error("write location did not load the limit");
   power_val_a: assert property (!seen_r
      |-> loc_r == VALUE_RST && remh_r == VALUE_RST)
      else $error("value not minus 128 before first conversion");
   rd_first_a: assert property (state_r == ST_AACK && scl_fall
      && !oe_n_r && rw_r && !start_c && !stop_c
      |=> sda_oe_n == $past(rd_byte[7]) ##1 state_r == ST_READ)
      else $error("read did not start with pointed register");
endmodule : temp_monitor_register_access

// ### tb/smbus_host_model.sv
// Purpose: Behavioural bus host that issues register reads and writes.
// Assumes: The bench resolves the open-drain data wire with a pull-up.
// Notes:   Each bus phase lasts QTR clocks, well above the minimum
//          high and low times, so slow synchronisers still see every edge.
`timescale 1ns/1ps
module smbus_host_model #(
   parameter int QTR = 8
)(
   input  wire logic clk,
   input  wire logic sda_wire,
   output logic      scl,
   output logic      sda_low
);
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   task automatic q();
      repeat (QTR) @(posedge clk);
      #1;
   endtask : q

   // Data changes only while the clock is low; sampled mid-high.
   task automatic bit_io(input logic b, output logic s);
      sda_low = ~b;
      q();
      scl = 1'b1;
      q();
      s = sda_wire;
      q();
      scl = 1'b0;
      q();
   endtask : bit_io

   task automatic start();
      sda_low = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_low = 1'b1;
      q();
      scl = 1'b0;
      q();
   endtask : start

   task automatic stop();
      sda_low = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_low = 1'b0;
      q();
   endtask : stop

   task automatic byte_io(input logic [7:0] tx, input logic ack_in,
                          output logic [7:0] rx, output logic nak);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], s);
         rx[i] = s;
      end
      bit_io(ack_in, nak);
   endtask : byte_io

   // First byte after the address is always the pointer.
   task automatic wr(input logic [6:0] a, input logic [7:0] ptr,
                     input int n, input logic [7:0] d, output logic nak);
      logic [7:0] rx;
      logic       k;
      start();
      byte_io({a, 1'b0}, 1'b1, rx, nak);
      byte_io(ptr, 1'b1, rx, k);
      nak = nak | k;
      for (int i = 0; i < n; i++) begin
         byte_io(d, 1'b1, rx, k);
         nak = nak | k;
      end
      stop();
   endtask : wr

   // Two data bytes: the first is acknowledged, the second is not.
   task automatic rd(input logic [6:0] a, output logic [7:0] d0,
                     output logic [7:0] d1, output logic nak);
      logic k;
      start();
      byte_io({a, 1'b1}, 1'b1, d0, nak);
      byte_io(8'hff, 1'b0, d0, k);
      byte_io(8'hff, 1'b1, d1, k);
      stop();
   endtask : rd
endmodule : smbus_host_model

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the thermometer register block.
// Assumes: The host model issues whole transactions; converter is driven here.
// Notes:   Expected bytes are worked out from eighth-degree converter codes.
`timescale 1ns/1ps
module tb_top;
   import temp_regs_pkg::*;
   localparam logic [6:0] DEV   = 7'h4c;
   localparam int         LIMIT = 90000;
   logic              clk;
   logic              rstn;
   logic              scl;
   logic              sda_low;
   logic              sda_wire;
   logic              sda_out;
   logic              sda_oe_n;
   logic              conv_valid;
   logic [CODE_W-1:0] conv_local;
   logic [CODE_W-1:0] conv_remote;
   logic [FLAG_N-1:0] limit_flags;
   logic [7:0]        d0;
   logic [7:0]        d1;
   logic              nak;
   int                num_errors = 0;
   int                n_checks   = 0;
   int                cycles     = 0;
   int                codes [6]  = '{0, 1, 7, 200, 805, 1023};

   // Released wire floats high through the pull-up.
   assign sda_wire = sda_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);

   temp_monitor_register_access #(
      .DEV_ADDR (DEV)
   ) temp_monitor_register_access_inst (
      .clk         (clk),
      .rstn        (rstn),
      .scl_pin     (scl),
      .sda_pin     (sda_wire),
      .sda_out     (sda_out),
      .sda_oe_n    (sda_oe_n),
      .conv_valid  (conv_valid),
      .conv_local  (conv_local),
      .conv_remote (conv_remote),
      .limit_flags (limit_flags)
   );

   smbus_host_model #(
      .QTR (8)
   ) smbus_host_model_inst (
      .clk      (clk),
      .sda_wire (sda_wire),
      .scl      (scl),
      .sda_low  (sda_low)
   );

   always #12.5 clk = ~clk;

   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish

   // A hung bus would otherwise stall the run forever.
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == LIMIT) begin
         num_errors = num_errors + 1;
         tally_and_finish();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic peek_chk(input logic [7:0] ptr, input logic [7:0] exp);
      smbus_host_model_inst.wr(DEV, ptr, 0, 8'h00, nak);
      check({7'h0, nak}, 8'h00);
      smbus_host_model_inst.rd(DEV, d0, d1, nak);
      check(d0, exp);
      check(d1, exp);
   endtask : peek_chk

   task automatic conv(input int l, input int r);
      @(posedge clk);
      #1;
      conv_valid  = 1'b1;
      conv_local  = CODE_W'(l);
      conv_remote = CODE_W'(r);
      @(posedge clk);
      #1;
      conv_valid = 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask : conv

   initial begin
      clk         = 1'b0;
      rstn        = 1'b0;
      conv_valid  = 1'b0;
      conv_local  = '0;
      conv_remote = '0;
      repeat (10) @(posedge clk);
      #1;
      rstn = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      peek_chk(PTR_RD_LOC, VALUE_RST);
      peek_chk(PTR_RD_REMH, VALUE_RST);
      peek_chk(PTR_RD_REML, LOWB_RST);
      peek_chk(PTR_RD_LHI, HI_LIM_RST);
      peek_chk(8'h30, RD_UNMAPPED);
      for (int i = 0; i < 6; i++) begin
         conv(codes[i], codes[5-i]);
         peek_chk(PTR_RD_LOC, 8'(codes[i] / 8));
         peek_chk(PTR_RD_REMH, 8'(codes[5-i] / 8));
         peek_chk(PTR_RD_REML, 8'((codes[5-i] % 8) * 32));
      end
      // Deliberate write to a value location: acknowledged, then dropped.
      smbus_host_model_inst.wr(DEV, PTR_RD_LOC, 1, 8'h55, nak);
      check({7'h0, nak}, 8'h00);
      peek_chk(PTR_RD_LOC, 8'h7f);
      smbus_host_model_inst.wr(DEV, PTR_WR_LHI, 1, 8'h19, nak);
      smbus_host_model_inst.wr(DEV, PTR_WR_LLO, 1, 8'h14, nak);
      smbus_host_model_inst.wr(DEV, PTR_WR_RLO, 1, 8'h0a, nak);
      peek_chk(PTR_RD_LHI, 8'h19);
      smbus_host_model_inst.rd(DEV, d0, d1, nak);
      check(d0, 8'h19);
      peek_chk(PTR_RD_LLO, 8'h14);
      peek_chk(PTR_RD_REMH, 8'h00);
      conv(208, 79);
      check({4'h0, limit_flags}, 8'h09);
      conv(152, 80);
      check({4'h0, limit_flags}, 8'h04);
      conv(200, 160);
      check({4'h0, limit_flags}, 8'h00);
      // Remote high limit of 20.125 degrees exercises the low byte too.
      smbus_host_model_inst.wr(DEV, PTR_WR_RHI, 1, 8'h14, nak);
      smbus_host_model_inst.wr(DEV, PTR_WR_RHIL, 1, 8'h20, nak);
      peek_chk(PTR_RD_RHIL, 8'h20);
      peek_chk(PTR_RD_RLO, 8'h0a);
      conv(200, 162);
      check({4'h0, limit_flags}, 8'h02);
      conv(200, 161);
      check({4'h0, limit_flags}, 8'h00);
      smbus_host_model_inst.rd(DEV ^ 7'h01, d0, d1, nak);
      check({7'h0, nak}, 8'h01);
      tally_and_finish();
   end
endmodule : tb_top
